// file: hdl/stc_timer.sv
// stc_timer: 16-bit timer/counter with apb registers, divider, overflow irq
// assumes: pclk is the system clock; ext pin input asynchronous to it
// Operation
// - counting only while run bit set; clearing holds the count
// - internal source counts every fourth clock; external counts rising edges
// - bypass bit skips synchroniser for external source only; here the bypass path still passes two pclk flops
// - divider selects 1:1, 1:2, 1:4 or 1:8 before the counter
// - oscillator enable bit drives the crystal oscillator enable output
// - read-only bit shows crystal oscillator is the system clock
// - wide bit selects buffered 16-bit access, else direct bytes
// - low byte read copies live high byte into high buffer
// - high write loads buffer; low write loads both bytes together
// - low byte write clears divider; high byte write leaves it
// - count wraps FFFF to 0000 and sets sticky overflow flag
// - interrupt only when overflow flag and its enable both set
// - while running the two pins are inputs and read as zero
// - oscillator keeps running in power-managed modes once enabled
// - special-event reset clears count in sync modes, no flag
// - a software count write wins over a coincident special-event reset
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module stc_timer
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_count_input,
  input  wire logic        crystal_in_pin,
  input  wire logic        sys_clk_from_crystal,
  input  wire logic        special_event_reset,
  input  wire logic [1:0]  port_c_direction,
  input  wire logic [1:0]  port_c_pin_in,
  output logic [1:0]       port_c_pin_in_view,
  output logic [1:0]       port_c_pin_oe_allowed,
  output logic             crystal_osc_enable,
  output logic             irq
);
  import stc_pkg::*;
  logic [7:0]  control_ff, nxt_control;
  logic [15:0] count_ff, nxt_count;
  logic [7:0]  hibuf_ff, nxt_hibuf;
  logic        ovf_ff, nxt_ovf;
  logic        mask_ff, nxt_mask;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        rd_done_ff, nxt_rd_done;
  logic        rd_cap;
  logic [2:0]  lvl_raw, lvl_q;
  logic [1:0]  instr_ff, nxt_instr;
  logic        async_meta_ff, async_sync_ff, async_prev_ff;
  logic        sync_rise;
  logic        src_pin;
  logic        raw_tick, div_tick, wr_lo, wr_hi, rd_lo, acc;
  logic        run, wide;
  stc_mode_t   mode;
  assign run  = control_ff[BIT_RUN];
  assign wide = control_ff[BIT_WIDE];
  assign mode = !control_ff[BIT_SRC] ? STC_SRC_INT :
                (control_ff[BIT_NOSYNC] ? STC_SRC_ASYNC : STC_SRC_SYNC);
  // crystal or external pin feeds the same source, oscillator preferred when on
  assign src_pin = control_ff[BIT_OSCEN] ? crystal_in_pin : ext_count_input;
  // synchronised path
  stc_sync u_sync
  (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (src_pin),
    .q     (),
    .rise  (sync_rise)
  );
  // slow level pins also pass two flops before any read mux sees them
  assign lvl_raw = {sys_clk_from_crystal, port_c_pin_in};
  for (genvar i = 0; i < 3; i++)
  begin : g_lvl
    stc_sync u_lvl
    (
      .clk   (pclk),
      .rst_n (presetn),
      .d     (lvl_raw[i]),
      .q     (lvl_q[i]),
      .rise  ()
    );
  end
  // bypass path: still sampled into pclk through two flops, same latency as the synchroniser
  // limitation: true asynchronous clocking is modelled on pclk in this block
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      async_meta_ff <= 1'b0;
      async_sync_ff <= 1'b0;
      async_prev_ff <= 1'b0;
    end
    else
    begin
      async_meta_ff <= src_pin;
      async_sync_ff <= async_meta_ff;
      async_prev_ff <= async_sync_ff;
    end
  end
  // instruction-cycle prescale: one tick in four clocks
  always_comb
  begin
    nxt_instr = instr_ff + 2'd1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      instr_ff <= 2'd0;
    else
      instr_ff <= nxt_instr;
  end
  // source select
  always_comb
  begin
    case (mode)
      STC_SRC_INT:  raw_tick = (instr_ff == INSTR_DIV_LAST);
      STC_SRC_SYNC: raw_tick = sync_rise;
      default:      raw_tick = async_sync_ff & ~async_prev_ff;
    endcase
    raw_tick = raw_tick & run;
  end
  stc_divider #(.WIDTH(3)) u_div
  (
    .clk      (pclk),
    .rst_n    (presetn),
    .tick_in  (raw_tick),
    .sel      (control_ff[BIT_DIV_LO+1:BIT_DIV_LO]),
    .clear    (wr_lo),
    .tick_out (div_tick)
  );
  // apb decode: writes are zero-wait; reads take one wait state
  // trade-off: the wait lets read data leave a flop, and read side effects fire once
  assign acc     = psel && penable;
  assign rd_cap  = acc && !pwrite && !rd_done_ff;
  assign pready  = pwrite || rd_done_ff;
  assign pslverr = 1'b0;
  assign wr_lo   = acc && pwrite && (paddr == ADDR_COUNT_LO);
  assign wr_hi   = acc && pwrite && (paddr == ADDR_COUNT_HI);
  assign rd_lo   = rd_cap && (paddr == ADDR_COUNT_LO);
  // read capture marker: high for the ready cycle only
  always_comb
  begin
    nxt_rd_done = rd_cap;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rd_done_ff <= 1'b0;
    else
      rd_done_ff <= nxt_rd_done;
  end
  // register and counter next state
  always_comb
  begin
    nxt_control = control_ff;
    nxt_count   = count_ff;
    nxt_hibuf   = hibuf_ff;
    nxt_ovf     = ovf_ff;
    nxt_mask    = mask_ff;
    nxt_prdata  = prdata_ff;
    if (div_tick)
    begin
      nxt_count = count_ff + 16'h0001;
    end
    if (special_event_reset && mode != STC_SRC_ASYNC)
      nxt_count = COUNT_RESET;
    if (acc && pwrite)
    begin
      if (paddr == ADDR_CONTROL)
      begin
        nxt_control = pwdata[7:0] & 8'hBF; // status bit read-only
      end
      else if (paddr == ADDR_COUNT_LO)
      begin
        if (wide)
          nxt_count = {hibuf_ff, pwdata[7:0]};
        else
          nxt_count = {nxt_count[15:8], pwdata[7:0]};
      end
      else if (paddr == ADDR_COUNT_HI)
      begin
        if (wide)
          nxt_hibuf = pwdata[7:0];
        else
          nxt_count = {pwdata[7:0], nxt_count[7:0]};
      end
      else if (paddr == ADDR_MASK)
      begin
        nxt_mask = pwdata[BIT_OVF];
      end
    end
    if (rd_cap)
    begin
      if (paddr == ADDR_CONTROL)
        nxt_prdata = {24'h0000_00, control_ff[7], lvl_q[2], control_ff[5:0]};
      else if (paddr == ADDR_COUNT_LO)
      begin
        nxt_prdata = {24'h0000_00, count_ff[7:0]};
        if (wide)
          nxt_hibuf = count_ff[15:8];
      end
      else if (paddr == ADDR_COUNT_HI)
        nxt_prdata = {24'h0000_00, wide ? hibuf_ff : count_ff[15:8]};
      else if (paddr == ADDR_STATUS)
      begin
        nxt_prdata = {31'h0000_0000, ovf_ff};
        nxt_ovf    = 1'b0; // read clears
      end
      else if (paddr == ADDR_MASK)
        nxt_prdata = {31'h0000_0000, mask_ff};
      else if (paddr == ADDR_PORT)
        nxt_prdata = {30'h0000_0000, port_c_pin_in_view};
      else
        nxt_prdata = 32'h0000_0000;
    end
    if (div_tick && count_ff == 16'hFFFF && !(wr_lo || (wr_hi && !wide)))
      nxt_ovf = 1'b1; // set wins over clear
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control_ff <= CONTROL_RESET;
      count_ff   <= COUNT_RESET;
      hibuf_ff   <= 8'h00;
      ovf_ff     <= 1'b0;
      mask_ff    <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      control_ff <= nxt_control;
      count_ff   <= nxt_count;
      hibuf_ff   <= nxt_hibuf;
      ovf_ff     <= nxt_ovf;
      mask_ff    <= nxt_mask;
      prdata_ff  <= nxt_prdata;
    end
  end
  // read data leaves the capture flop, taken at the wait edge with its side effects
  assign prdata = prdata_ff;
  // pins forced to input while running, and read as zero
  assign port_c_pin_oe_allowed = run ? 2'b00 : ~port_c_direction;
  assign port_c_pin_in_view    = run ? 2'b00 : lvl_q[1:0];
  // oscillator has no power-mode gating here, so it runs whenever enabled
  assign crystal_osc_enable = control_ff[BIT_OSCEN];
  assign irq                = ovf_ff & mask_ff;

  // assertions
  halt_holds_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!run && !acc && !special_event_reset) |=> $stable(count_ff)) else $error("count moved while stopped");
  wrap_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (div_tick && count_ff == 16'hFFFF && !acc && !special_event_reset) |=> (count_ff == 16'h0000 && ovf_ff))
    else $error("wrap did not set flag");
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq == (ovf_ff && mask_ff)) else $error("irq not gated");
  wide_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_lo && wide) |=> count_ff == {$past(hibuf_ff), $past(pwdata[7:0])}) else $error("wide write wrong");
  hi_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_lo && wide) |=> hibuf_ff == $past(count_ff[15:8])) else $error("high buffer not captured");
  event_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (special_event_reset && mode != STC_SRC_ASYNC && !acc) |=> count_ff == 16'h0000) else $error("reset ignored");
  pins_input_a: assert property (@(posedge pclk) disable iff (!presetn)
    run |-> (port_c_pin_oe_allowed == 2'b00 && port_c_pin_in_view == 2'b00)) else $error("pins not forced");
  instr_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == STC_SRC_INT && raw_tick) |=> !raw_tick [*3]) else $error("internal rate wrong");
  osc_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    crystal_osc_enable == control_ff[BIT_OSCEN]) else $error("oscillator enable mismatch");
  event_noflag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (special_event_reset && !rd_cap && !(div_tick && count_ff == 16'hFFFF)) |=> ovf_ff == $past(ovf_ff))
    else $error("event reset touched flag");
  write_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_lo && !wide && special_event_reset) |=> count_ff[7:0] == $past(pwdata[7:0])) else $error("event beat write");
  status_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_cap && paddr == ADDR_STATUS && !(div_tick && count_ff == 16'hFFFF)) |=> !ovf_ff)
    else $error("status read did not clear");
  secclk_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
    control_ff[BIT_SECCLK] == 1'b0) else $error("status bit stored");
  cov_wrap: cover property (@(posedge pclk) disable iff (!presetn) div_tick && count_ff == 16'hFFFF);
  cov_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  cov_sync: cover property (@(posedge pclk) disable iff (!presetn) mode == STC_SRC_SYNC && div_tick);
  cov_wide_rd: cover property (@(posedge pclk) disable iff (!presetn) rd_lo && wide);
  cov_ev_write: cover property (@(posedge pclk) disable iff (!presetn) wr_lo && special_event_reset);
endmodule
`default_nettype wire

// file: hdl/stc_pkg.sv
// stc_pkg: register map, field positions and reset values of the 16-bit timer/counter
// assumes: apb slave with 32-bit data, one register per aligned word
package stc_pkg;
  localparam logic [11:0] ADDR_CONTROL   = 12'h000;
  localparam logic [11:0] ADDR_COUNT_LO  = 12'h004;
  localparam logic [11:0] ADDR_COUNT_HI  = 12'h008;
  localparam logic [11:0] ADDR_STATUS    = 12'h00C;
  localparam logic [11:0] ADDR_MASK      = 12'h010;
  localparam logic [11:0] ADDR_PORT      = 12'h014;
  localparam int          BIT_RUN        = 0;
  localparam int          BIT_SRC        = 1;
  localparam int          BIT_NOSYNC     = 2;
  localparam int          BIT_OSCEN      = 3;
  localparam int          BIT_DIV_LO     = 4;
  localparam int          BIT_SECCLK     = 6;
  localparam int          BIT_WIDE       = 7;
  localparam int          BIT_OVF        = 0;
  localparam logic [7:0]  CONTROL_RESET  = 8'h00;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [1:0]  INSTR_DIV_LAST = 2'h3;
  localparam int          SYNC_STAGES    = 2;
  typedef enum logic [1:0] {STC_SRC_INT = 2'b00, STC_SRC_SYNC = 2'b01, STC_SRC_ASYNC = 2'b11} stc_mode_t;
endpackage

// file: hdl/stc_sync.sv
// stc_sync: two-flop synchroniser with rising-edge detect
// assumes: d is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module stc_sync
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q,
  output logic      rise
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  // first flop feeds only the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= d;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end
  assign q    = sync_ff;
  assign rise = sync_ff & ~prev_ff;
endmodule
`default_nettype wire

// file: hdl/stc_divider.sv
// stc_divider: 1/2/4/8 input divider producing one tick per n inputs
// assumes: tick_in is a one-cycle pulse on clk
`timescale 1ns/1ps
`default_nettype none
module stc_divider
#(
  parameter int WIDTH = 3
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick_in,
  input  wire logic [1:0] sel,
  input  wire logic       clear,
  output logic            tick_out
);
  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;
  logic [WIDTH-1:0] last;
  initial
  begin
    if (WIDTH < 3) $error("divider width must be at least 3");
  end
  // terminal count 2**sel - 1
  always_comb
  begin
    last     = WIDTH'((1 << sel) - 1);
    nxt_cnt  = cnt_ff;
    tick_out = tick_in && (cnt_ff >= last);
    if (clear)
      nxt_cnt = '0;
    else if (tick_in)
      nxt_cnt = (cnt_ff >= last) ? '0 : cnt_ff + 1'b1;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end
endmodule
`default_nettype wire

// file: bench/stc_timer_test.sv
// stc_timer_test: self-checking bench for the 16-bit timer/counter
// assumes: stc_pkg register map, apb slave that may insert wait states, single pclk domain
`timescale 1ns/1ps
`default_nettype none
module stc_timer_test;
  import stc_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        err_seen = 1'b0;
  logic        ext = 1'b0;
  logic        xtal = 1'b0;
  logic        sysx = 1'b0;
  logic        ser = 1'b0;
  logic        ev_w = 1'b0;
  logic [1:0]  pdir = '0;
  logic [1:0]  pin = '0;
  logic [1:0]  view;
  logic [1:0]  oe;
  logic        osc_en;
  logic        irq;
  logic [15:0] c;
  logic [15:0] c2;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          e;
  int          w;
  int          n;

  // 25 MHz system clock
  always #20 pclk = ~pclk;

  stc_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_input(ext), .crystal_in_pin(xtal), .sys_clk_from_crystal(sysx),
    .special_event_reset(ser), .port_c_direction(pdir), .port_c_pin_in(pin),
    .port_c_pin_in_view(view), .port_c_pin_oe_allowed(oe), .crystal_osc_enable(osc_en), .irq(irq));

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; the event pulse may ride the access phase on purpose
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    ser     <= ev_w;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    q = prdata;
    err_seen = err_seen | pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    ser     <= 1'b0;
    // let this edge's register updates settle before callers look at outputs
    @(negedge pclk);
    if (k >= 50)
    begin
      n_mismatch++;
      complete_run();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, '0, q);
    check(q, exp);
  endtask

  task automatic rdcnt(output logic [15:0] v);
    logic [31:0] lo;
    logic [31:0] hi;
    apb(1'b0, ADDR_COUNT_LO, '0, lo);
    apb(1'b0, ADDR_COUNT_HI, '0, hi);
    v = {hi[7:0], lo[7:0]};
  endtask

  function automatic logic [31:0] ctl(input int run, src, nsy, osc, div, wide);
    return 32'((run << BIT_RUN) | (src << BIT_SRC) | (nsy << BIT_NOSYNC) | (osc << BIT_OSCEN)
      | (div << BIT_DIV_LO) | (wide << BIT_WIDE));
  endfunction

  // instruction ticks seen in a window, after a divide by 2**div
  function automatic int exp_ticks(input int cyc, input int div);
    return cyc / (4 << div);
  endfunction

  initial
  begin
    void'($urandom(32'h80f4_f66f));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ADDR_CONTROL, 32'h0000_0000);
    check(32'({osc_en, irq}), 32'h0000_0000);
    wr(ADDR_CONTROL, 32'h0000_00FF);
    check(32'(osc_en), 32'h0000_0001);
    rdc(ADDR_CONTROL, 32'h0000_00BF);
    @(posedge pclk) sysx <= 1'b1;
    rdc(ADDR_CONTROL, 32'h0000_00FF);
    wr(ADDR_CONTROL, 32'h0000_0000);
    wr(12'h018, 32'hFFFF_FFFF);
    rdc(12'h018, 32'h0000_0000);
    $display("test control done");
    // internal source through every divider ratio, pins released while running
    for (int d = 0; d < 4; d++)
    begin
      @(posedge pclk) pin <= 2'($urandom); pdir <= 2'($urandom);
      wr(ADDR_COUNT_HI, 32'h0000_0000);
      wr(ADDR_COUNT_LO, 32'h0000_0000);
      check(32'({view, oe}), 32'({pin, ~pdir}));
      w = 70 + $urandom_range(60);
      wr(ADDR_CONTROL, ctl(1, 0, 1, 0, d, 0));
      check(32'({view, oe}), 32'h0000_0000);
      repeat (w) @(posedge pclk);
      wr(ADDR_CONTROL, ctl(0, 0, 0, 0, d, 0));
      rdcnt(c);
      e = exp_ticks(w + 3, 0) >> d;
      check(32'(c >= e - 1 && c <= e + 1), 32'h0000_0001);
      repeat (10) @(posedge pclk);
      rdcnt(c2);
      check(32'(c2), 32'(c));
    end
    $display("test divider done");
    // external edges: synchronised, bypassed, and from the crystal pin
    for (int k = 0; k < 3; k++)
    begin
      wr(ADDR_COUNT_HI, 32'h0000_0000);
      wr(ADDR_COUNT_LO, 32'h0000_0000);
      n = 1 + $urandom_range(9);
      wr(ADDR_CONTROL, ctl(1, 1, k == 1, k == 2, 0, 0));
      check(32'(osc_en), 32'(k == 2));
      if (k == 2) repeat (20) @(posedge pclk);
      for (int i = 0; i < n; i++)
      begin
        @(posedge pclk) if (k == 2) xtal <= 1'b1; else ext <= 1'b1;
        repeat (4) @(posedge pclk);
        xtal <= 1'b0; ext <= 1'b0;
        repeat (4) @(posedge pclk);
      end
      repeat (8) @(posedge pclk);
      wr(ADDR_CONTROL, 32'h0000_0000);
      rdcnt(c);
      check(32'(c), 32'(n));
    end
    $display("test external done");
    // buffered access against direct byte access
    wr(ADDR_COUNT_HI, 32'h0000_00AA);
    wr(ADDR_CONTROL, ctl(0, 0, 0, 0, 0, 1));
    wr(ADDR_COUNT_HI, 32'h0000_0012);
    wr(ADDR_CONTROL, 32'h0000_0000);
    rdc(ADDR_COUNT_HI, 32'h0000_00AA);
    wr(ADDR_CONTROL, ctl(0, 0, 0, 0, 0, 1));
    wr(ADDR_COUNT_LO, 32'h0000_0034);
    wr(ADDR_CONTROL, 32'h0000_0000);
    rdc(ADDR_COUNT_HI, 32'h0000_0012);
    rdc(ADDR_COUNT_LO, 32'h0000_0034);
    wr(ADDR_COUNT_HI, 32'h0000_0056);
    wr(ADDR_CONTROL, ctl(0, 0, 0, 0, 0, 1));
    rdc(ADDR_COUNT_LO, 32'h0000_0034);
    rdc(ADDR_COUNT_HI, 32'h0000_0056);
    wr(ADDR_CONTROL, 32'h0000_0000);
    $display("test wide done");
    // wrap, sticky flag, mask and clear on read
    wr(ADDR_MASK, 32'h0000_0001);
    wr(ADDR_COUNT_HI, 32'h0000_00FF);
    wr(ADDR_COUNT_LO, 32'h0000_00FE);
    rdc(ADDR_STATUS, 32'h0000_0000);
    wr(ADDR_CONTROL, ctl(1, 0, 0, 0, 0, 0));
    repeat (20) @(posedge pclk);
    wr(ADDR_CONTROL, 32'h0000_0000);
    rdcnt(c);
    check(32'(c < 16'h0010), 32'h0000_0001);
    check(32'(irq), 32'h0000_0001);
    wr(ADDR_MASK, 32'h0000_0000);
    check(32'(irq), 32'h0000_0000);
    wr(ADDR_MASK, 32'h0000_0001);
    rdc(ADDR_STATUS, 32'h0000_0001);
    check(32'(irq), 32'h0000_0000);
    rdc(ADDR_STATUS, 32'h0000_0000);
    $display("test overflow done");
    // special-event reset: clears in timer mode, loses to a write, ignored when unsynchronised
    wr(ADDR_COUNT_LO, 32'h0000_0055);
    @(posedge pclk) ser <= 1'b1;
    @(posedge pclk) ser <= 1'b0;
    rdc(ADDR_COUNT_LO, 32'h0000_0000);
    rdc(ADDR_STATUS, 32'h0000_0000);
    ev_w = 1'b1;
    wr(ADDR_COUNT_LO, 32'h0000_0077);
    ev_w = 1'b0;
    rdc(ADDR_COUNT_LO, 32'h0000_0077);
    wr(ADDR_CONTROL, ctl(0, 1, 1, 0, 0, 0));
    @(posedge pclk) ser <= 1'b1;
    @(posedge pclk) ser <= 1'b0;
    rdc(ADDR_COUNT_LO, 32'h0000_0077);
    $display("test event done");
    check(32'(err_seen), 32'h0000_0000);
    complete_run();
  end
endmodule
`default_nettype wire
